// ===== lcd_cascade_frame_sync.sv
/*
 * Frame timing and cascade synchronisation of a segment display driver.
 * Assumes all pins are synchronous to the core clock and that the sync and
 * clock wires are resolved outside from the drive levels and enables.
 */
// Behaviour
// - The frame lasts twenty-four ticks of the active display clock.
// - Up to sixteen devices are told apart by three subaddress pins plus the address bit.
// - The device index is the address bit on top of the three subaddress bits, 0 to 15.
// - Slaves run from the master's clock output and no other clock source is applied.
// - Synchronised devices produce aligned backplane phases so one set can serve all.
// - After reset every device starts its frame at the same point without sync activity.
// - The sync line is two-way and only ever pulled low, a pull-up returning it high.
// - Each device pulls sync at the onset of its last active backplane phase every frame, except the first frame after reset in static mode.
// - Outside its own pull interval a device watches the sync line as an input.
// - A foreign sync pull realigns the frame so the earliest puller sets the timing.
// - Realignment recovers from noise and from differing multiplex settings.
`timescale 1ns/1ps
module lcd_cascade_frame_sync
    import lcd_sync_pkg::*;
#(
    parameter int HALF_SLOW_CYCLES = DCLK_HALF_SLOW_CYC,
    parameter int HALF_FAST_CYCLES = DCLK_HALF_FAST_CYC
) (
    input wire logic core_clk_in,                  // 25 MHz core clock
    input wire logic rst_b_in,                     // Power-on reset, active low
    input wire logic clk_en_in,                    // Freezes all state when low
    input wire logic master_select_in,             // High: this device is master
    input wire logic frame_rate_select_in,         // High: slow rate
    input wire mux_mode_t mux_mode_in,             // Backplane multiplex mode
    input wire logic slave_address_low_bit_in,     // Address bit, index MSB
    input wire logic subaddress_pin_bit0_in,       // Subaddress bit 0
    input wire logic subaddress_pin_bit1_in,       // Subaddress bit 1
    input wire logic subaddress_pin_bit2_in,       // Subaddress bit 2
    input wire logic [3:0] bus_device_in,          // Index addressed on the bus
    input wire logic clk_pin_in,                   // Clock pin level
    output logic clk_pin_out,                      // Clock pin drive level
    output logic clk_pin_oe_b_out,                 // Low while driving clock pin
    input wire logic sync_line_in,                 // Sync line level
    output logic sync_line_out,                    // Sync drive level
    output logic sync_line_oe_b_out,               // Low while pulling sync
    output logic [3:0] backplane_outputs_out,      // One-hot active backplane
    output logic [3:0] device_index_out,           // Own device index
    output logic device_selected_out               // Bus index matches own
);

    // ------------------------------------------------------------
    // Display clock and sync line
    // ------------------------------------------------------------
    logic tick;
    logic sync_fall;
    logic drive_start;

    disp_clock_source #(
        .HALF_SLOW_CYCLES(HALF_SLOW_CYCLES),
        .HALF_FAST_CYCLES(HALF_FAST_CYCLES)
    ) u_clk (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .master_in(master_select_in),
        .rate_slow_in(frame_rate_select_in),
        .clk_pin_in(clk_pin_in),
        .clk_pin_out(clk_pin_out),
        .clk_pin_oe_b_out(clk_pin_oe_b_out),
        .tick_out(tick)
    );

    sync_line_port u_sync (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .clk_en_in(clk_en_in),
        .start_in(drive_start),
        .tick_in(tick),
        .sync_line_in(sync_line_in),
        .sync_line_out(sync_line_out),
        .sync_line_oe_b_out(sync_line_oe_b_out),
        .sync_fall_out(sync_fall)
    );

    // ------------------------------------------------------------
    // Frame position
    // ------------------------------------------------------------
    logic [4:0] pos_q, pos_d;
    logic [4:0] pos_inc;
    logic [4:0] onset;
    logic realign;

    always_comb begin
        onset = last_start(mux_mode_in);
        pos_inc = (pos_q >= FRAME_LAST) ? POS_RESET : pos_q + 5'h01;
        // A foreign pull while already at the onset means we are in step
        realign = sync_fall && (pos_q != onset);
        pos_d = pos_q;
        if (realign) begin
            pos_d = onset;
        end else if (tick) begin
            pos_d = pos_inc;
        end
        drive_start = realign || (tick && pos_inc == onset);
    end

    // Every device leaves reset at the same frame position
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_q <= POS_RESET;
        end else if (clk_en_in) begin
            pos_q <= pos_d;
        end
    end

    // ------------------------------------------------------------
    // Backplane phase and device index
    // ------------------------------------------------------------
    logic [3:0] bp_q, bp_d;
    logic [3:0] idx_q, idx_d;
    logic sel_q, sel_d;

    always_comb begin
        bp_d = phase_of(pos_d, mux_mode_in);
        idx_d = device_index(slave_address_low_bit_in,
            {subaddress_pin_bit2_in, subaddress_pin_bit1_in, subaddress_pin_bit0_in});
        sel_d = (idx_d == bus_device_in);
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bp_q <= BP_RESET;
            idx_q <= INDEX_RESET;
            sel_q <= 1'b0;
        end else if (clk_en_in) begin
            bp_q <= bp_d;
            idx_q <= idx_d;
            sel_q <= sel_d;
        end
    end

    assign backplane_outputs_out = bp_q;
    assign device_index_out = idx_q;
    assign device_selected_out = sel_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_frame_wrap;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (clk_en_in && tick && !realign && pos_q == FRAME_LAST) |=> (pos_q == POS_RESET);
    endproperty
    a_frame_wrap: assert property (p_frame_wrap)
        else $error("frame did not wrap after 24 ticks");

    property p_frame_step;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (clk_en_in && tick && !realign && pos_q < FRAME_LAST) |=> (pos_q == $past(pos_q) + 5'h01);
    endproperty
    a_frame_step: assert property (p_frame_step)
        else $error("frame position did not advance on a tick");

    property p_frame_hold;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (!tick && !realign) |=> $stable(pos_q);
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("frame position moved without a tick");

    property p_index;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in |=> (device_index_out == {$past(slave_address_low_bit_in),
            $past(subaddress_pin_bit2_in), $past(subaddress_pin_bit1_in),
            $past(subaddress_pin_bit0_in)});
    endproperty
    a_index: assert property (p_index)
        else $error("device index not formed from address bit and pins");

    property p_select;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in |=> (device_selected_out == (device_index_out == $past(bus_device_in)));
    endproperty
    a_select: assert property (p_select)
        else $error("device select does not match the bus index");

    property p_clk_slave;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !master_select_in |-> (clk_pin_oe_b_out && (tick == (clk_en_in && clk_pin_in
            && !$past(clk_pin_in))));
    endproperty
    a_clk_slave: assert property (p_clk_slave)
        else $error("slave drives the clock pin or ignores it");

    property p_clk_master;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        master_select_in |-> !clk_pin_oe_b_out;
    endproperty
    a_clk_master: assert property (p_clk_master)
        else $error("master does not drive the clock pin");

    property p_bp_onehot;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        $onehot(backplane_outputs_out) && (pos_q < FRAME_TICKS);
    endproperty
    a_bp_onehot: assert property (p_bp_onehot)
        else $error("backplane phase not one-hot or position out of frame");

    property p_bp_follows;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        clk_en_in |=>
            (backplane_outputs_out == phase_of(pos_q, $past(mux_mode_in)));
    endproperty
    a_bp_follows: assert property (p_bp_follows)
        else $error("backplane phase disagrees with frame position");

    // Static drive has one backplane only, so no other phase may ever light
    property p_bp_static;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (clk_en_in && mux_mode_in == MUX_STATIC) |=> (backplane_outputs_out == 4'h1);
    endproperty
    a_bp_static: assert property (p_bp_static)
        else $error("static mode showed a backplane other than the first");

    property p_open_drain;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        sync_line_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("sync line driven high");

    property p_sync_onset;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (clk_en_in && tick && !realign && pos_inc == onset) |=>
            (!sync_line_oe_b_out && pos_q == $past(onset));
    endproperty
    a_sync_onset: assert property (p_sync_onset)
        else $error("sync not pulled at onset of last backplane phase");

    // A pull at the onset must coincide with the last backplane showing
    property p_bp_last;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (!sync_line_oe_b_out && pos_q == onset && $stable(mux_mode_in)) |->
            (backplane_outputs_out == (4'h1 << mux_mode_in));
    endproperty
    a_bp_last: assert property (p_bp_last)
        else $error("own sync pull outside the last backplane phase");

    property p_pull_cause;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        $fell(sync_line_oe_b_out) |-> $past(drive_start);
    endproperty
    a_pull_cause: assert property (p_pull_cause)
        else $error("sync pulled without a frame onset or realign");

    property p_sync_release;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (!sync_line_oe_b_out && clk_en_in && tick && !drive_start) |=> sync_line_oe_b_out;
    endproperty
    a_sync_release: assert property (p_sync_release)
        else $error("sync held beyond one display clock");

    property p_watch_only_idle;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        realign |-> sync_line_oe_b_out;
    endproperty
    a_watch_only_idle: assert property (p_watch_only_idle)
        else $error("realigned on own sync pull");

    property p_realign;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        realign |=> (pos_q == $past(onset) && !sync_line_oe_b_out);
    endproperty
    a_realign: assert property (p_realign)
        else $error("foreign sync did not realign the frame");

    property p_realign_any_mode;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (clk_en_in && sync_line_oe_b_out && $past(sync_line_in) && !sync_line_in
            && pos_q != onset) |=> (pos_q == $past(onset));
    endproperty
    a_realign_any_mode: assert property (p_realign_any_mode)
        else $error("lost alignment not recovered");

    property p_reset_start;
        @(posedge core_clk_in)
        !rst_b_in |=> (pos_q == POS_RESET || !rst_b_in || tick || realign);
    endproperty
    a_reset_start: assert property (p_reset_start)
        else $error("frame does not start from zero after reset");

    property p_rate;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (master_select_in && frame_rate_select_in && clk_en_in && tick) |->
            (u_clk.half == 16'(HALF_SLOW_CYCLES - 1));
    endproperty
    a_rate: assert property (p_rate)
        else $error("rate select high did not pick the slow clock");

    c_realign: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) realign);
    c_own_sync: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
        tick && !realign && pos_inc == onset && mux_mode_in == MUX_4);
    c_wrap: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
        tick && pos_q == FRAME_LAST);
    c_slave_tick: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
        !master_select_in && tick);
    c_static_pull: cover property (@(posedge core_clk_in) disable iff (!rst_b_in)
        $fell(sync_line_oe_b_out) && mux_mode_in == MUX_STATIC);

endmodule // lcd_cascade_frame_sync

// ===== lcd_sync_pkg.sv
/*
 * Shared constants, types and helper functions of the cascade frame timing block.
 * Assumes a 25 MHz core clock that runs free from reset onward.
 */
package lcd_sync_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CORE_CLK_HZ = 25_000_000;
    localparam int DCLK_SLOW_HZ = 1970;   // Rate select high, ~82 Hz frame
    localparam int DCLK_FAST_HZ = 2640;   // Rate select low, ~110 Hz frame
    localparam int DCLK_HALF_SLOW_CYC = CORE_CLK_HZ / (2 * DCLK_SLOW_HZ);
    localparam int DCLK_HALF_FAST_CYC = CORE_CLK_HZ / (2 * DCLK_FAST_HZ);
    localparam logic [15:0] DIV_CNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_TICKS = 5'h18;   // 24 display clocks per frame
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] POS_RESET = 5'h00;
    localparam logic [3:0] BP_RESET = 4'h1;
    localparam logic [3:0] INDEX_RESET = 4'h0;

    typedef enum logic [1:0] {MUX_STATIC, MUX_2, MUX_3, MUX_4} mux_mode_t;

    function automatic logic [4:0] phase_len(input mux_mode_t m);
        unique case (m)
            MUX_STATIC: phase_len = 5'h18;
            MUX_2: phase_len = 5'h0c;
            MUX_3: phase_len = 5'h08;
            MUX_4: phase_len = 5'h06;
        endcase
    endfunction

    // Onset of the last active backplane phase
    function automatic logic [4:0] last_start(input mux_mode_t m);
        last_start = FRAME_TICKS - phase_len(m);
    endfunction

    // Active backplane phase, as a one-hot backplane vector
    function automatic logic [3:0] phase_of(input logic [4:0] pos, input mux_mode_t m);
        logic [4:0] len;
        logic [3:0] hot;
        len = phase_len(m);
        hot = 4'h1;
        if (pos >= 5'(3 * len) && m == MUX_4) begin
            hot = 4'h8;
        end else if (pos >= 5'(2 * len) && (m == MUX_3 || m == MUX_4)) begin
            hot = 4'h4;
        end else if (pos >= len) begin
            hot = 4'h2;
        end
        phase_of = hot;
    endfunction

    function automatic logic [3:0] device_index(input logic sa, input logic [2:0] sub);
        device_index = {sa, sub};
    endfunction

endpackage

// ===== disp_clock_source.sv
/*
 * Display clock source: internal divider for a master, clock pin receiver for a slave.
 * Assumes the clock pin input is already synchronous to the core clock.
 */
`timescale 1ns/1ps
module disp_clock_source
    import lcd_sync_pkg::*;
#(
    parameter int HALF_SLOW_CYCLES = DCLK_HALF_SLOW_CYC,
    parameter int HALF_FAST_CYCLES = DCLK_HALF_FAST_CYC
) (
    input wire logic core_clk_in,        // Core clock
    input wire logic rst_b_in,           // Async reset, active low
    input wire logic clk_en_in,          // Freezes state when low
    input wire logic master_in,          // Master drives the clock pin
    input wire logic rate_slow_in,       // High selects slower clock
    input wire logic clk_pin_in,         // Clock pin level
    output logic clk_pin_out,            // Clock pin drive level
    output logic clk_pin_oe_b_out,       // Low while driving the pin
    output logic tick_out                // One pulse per display clock
);

    logic [15:0] div_q, div_d;
    logic lvl_q, lvl_d;
    logic pin_q, pin_d;
    logic [15:0] half;

    always_comb begin
        half = rate_slow_in ? 16'(HALF_SLOW_CYCLES - 1) : 16'(HALF_FAST_CYCLES - 1);
        div_d = div_q;
        lvl_d = lvl_q;
        pin_d = clk_pin_in;
        if (div_q >= half) begin
            div_d = DIV_CNT_RESET;
            lvl_d = !lvl_q;
        end else begin
            div_d = div_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_q <= DIV_CNT_RESET;
            lvl_q <= 1'b0;
            pin_q <= 1'b0;
        end else if (clk_en_in) begin
            div_q <= div_d;
            lvl_q <= lvl_d;
            pin_q <= pin_d;
        end
    end

    // Slaves run on the received clock, never on their own divider
    assign clk_pin_out = lvl_q;
    assign clk_pin_oe_b_out = !master_in;
    assign tick_out = clk_en_in && (master_in ? (lvl_d && !lvl_q) : (clk_pin_in && !pin_q));

endmodule // disp_clock_source

// ===== sync_line_port.sv
/*
 * Open-drain cascade sync line: pulls low for one display clock, watches otherwise.
 * Assumes an external pull-up and a line level synchronous to the core clock.
 */
`timescale 1ns/1ps
module sync_line_port (
    input wire logic core_clk_in,        // Core clock
    input wire logic rst_b_in,           // Async reset, active low
    input wire logic clk_en_in,          // Freezes state when low
    input wire logic start_in,           // Begin pulling the line low
    input wire logic tick_in,            // Display clock pulse
    input wire logic sync_line_in,       // Line level
    output logic sync_line_out,          // Drive level, always low
    output logic sync_line_oe_b_out,     // Low while pulling low
    output logic sync_fall_out           // Fall caused by another device
);

    typedef enum logic {SYNC_IDLE, SYNC_DRIVE} sync_state_t;

    sync_state_t state_q, state_d;
    logic prev_q, prev_d;

    always_comb begin
        state_d = state_q;
        prev_d = sync_line_in;
        unique case (state_q)
            SYNC_IDLE: begin
                if (start_in) begin
                    state_d = SYNC_DRIVE;
                end
            end
            SYNC_DRIVE: begin
                if (tick_in && !start_in) begin
                    state_d = SYNC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= SYNC_IDLE;
            prev_q <= 1'b1;
        end else if (clk_en_in) begin
            state_q <= state_d;
            prev_q <= prev_d;
        end
    end

    assign sync_line_out = 1'b0;
    assign sync_line_oe_b_out = (state_q != SYNC_DRIVE);
    // Only watched while this end is not pulling, so its own drive is never seen as foreign
    assign sync_fall_out = clk_en_in && prev_q && !sync_line_in && (state_q == SYNC_IDLE);

endmodule // sync_line_port

// ===== cascade_peer_model.sv
/*
 * Model of a second cascaded driver sharing the clock pin and sync wire.
 * Assumes the clock pin and resolved sync wire are synchronous to the core clock.
 */
`timescale 1ns/1ps
module cascade_peer_model
    import lcd_sync_pkg::*;
(
    input wire logic core_clk_in,        // Core clock
    input wire logic rst_b_in,           // Power-on reset, active low
    input wire logic clk_pin_in,         // Clock from the master
    input wire mux_mode_t mux_mode_in,   // Multiplex mode
    input wire logic skew_in,            // Noise: one extra frame step
    output logic sync_line_out,          // Drive level, always low
    output logic sync_line_oe_b_out      // Low while pulling sync
);
    logic pin_q;
    logic [4:0] pos_q;
    logic [4:0] onset;
    logic [4:0] nxt;
    always_comb begin
        case (mux_mode_in)
            MUX_STATIC: onset = 5'h00;
            MUX_2: onset = 5'h0c;
            MUX_3: onset = 5'h10;
            default: onset = 5'h12;
        endcase
    end
    assign nxt = (pos_q == 5'h17) ? 5'h00 : pos_q + 5'h01;
    assign sync_line_out = 1'b0;
    // ------------------------------------------------------------
    // Frame position, stepped by clock pin rises and by skew pulses
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_q <= 1'b0;
            pos_q <= 5'h00;
            sync_line_oe_b_out <= 1'b1;
        end else begin
            pin_q <= clk_pin_in;
            if (clk_pin_in && !pin_q) begin
                pos_q <= nxt;
                sync_line_oe_b_out <= (nxt != onset);
            end else if (skew_in) begin
                pos_q <= nxt;
            end
        end
    end
endmodule // cascade_peer_model

// ===== lcd_cascade_frame_sync_tb.sv
/*
 * Self-checking bench: index, slave frame timing, sync realign, master clock.
 * Assumes small half-period parameters so the master clock runs quickly.
 */
`timescale 1ns/1ps
module lcd_cascade_frame_sync_tb;
    import lcd_sync_pkg::*;
    logic core_clk_in = 1'b0, rst_b_in = 1'b0, master = 1'b0, rate = 1'b0, sa = 1'b0;
    logic [2:0] sub = 3'h0;
    logic [3:0] bus_dev = 4'h0;
    logic tb_pin = 1'b0, skew = 1'b0;
    mux_mode_t mode = MUX_STATIC;
    logic pin_o, pin_oe_b, sync_o, sync_oe_b, sel, p_sync, p_oe_b;
    logic [3:0] bp, idx;
    int seed = 17, miscompares = 0, total_checks = 0, cyc = 0, t, t_last, n;
    bit skewed, was_pull;
    wire pin_w = master ? pin_o : tb_pin;
    wire sync_w = (sync_oe_b === 1'b0 || p_oe_b === 1'b0) ? 1'b0 : 1'b1;
    always #20 core_clk_in = ~core_clk_in;
    lcd_cascade_frame_sync #(.HALF_SLOW_CYCLES(4), .HALF_FAST_CYCLES(3)) u_dut (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1),
        .master_select_in(master), .frame_rate_select_in(rate), .mux_mode_in(mode),
        .slave_address_low_bit_in(sa), .subaddress_pin_bit0_in(sub[0]),
        .subaddress_pin_bit1_in(sub[1]), .subaddress_pin_bit2_in(sub[2]),
        .bus_device_in(bus_dev), .clk_pin_in(pin_w), .clk_pin_out(pin_o),
        .clk_pin_oe_b_out(pin_oe_b), .sync_line_in(sync_w), .sync_line_out(sync_o),
        .sync_line_oe_b_out(sync_oe_b), .backplane_outputs_out(bp),
        .device_index_out(idx), .device_selected_out(sel));
    cascade_peer_model u_peer (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .clk_pin_in(pin_w), .mux_mode_in(mode), .skew_in(skew),
        .sync_line_out(p_sync), .sync_line_oe_b_out(p_oe_b));
    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic int first_pull(mux_mode_t m);
        first_pull = (m == MUX_STATIC) ? 24 : 24 - 24 / (int'(m) + 1);
    endfunction
    function automatic logic [3:0] last_bp(mux_mode_t m);
        last_bp = 4'h1 << int'(m);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Runaway guard, far above the expected run length
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic do_reset();
        rst_b_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        #1 rst_b_in = 1'b1;
        t = 0;
        t_last = 0;
        skewed = 0;
        was_pull = 0;
    endtask
    // Random high and low time stresses the edge detector, not just one spacing
    task automatic tick();
        int h;
        h = 3 + ($unsigned($random(seed)) % 3);
        tb_pin = 1'b1;
        repeat (h) @(posedge core_clk_in);
        #1 t++;
        if (mode == MUX_STATIC) chk(bp, 4'h1);
        if (p_oe_b === 1'b0) begin
            chk(sync_oe_b, 1'b0);
            chk(bp, last_bp(mode));
        end
        if (sync_oe_b === 1'b0 && !was_pull) begin
            chk(sync_o, 1'b0);
            if (t_last == 0) chk(t, first_pull(mode));
            else if (!skewed) chk(t - t_last, 24);
            t_last = t;
        end
        was_pull = (sync_oe_b === 1'b0);
        tb_pin = 1'b0;
        repeat (h) @(posedge core_clk_in);
        #1;
    endtask
    task automatic rise_gap(output int c);
        c = 0;
        @(posedge pin_o);
        #1 while (pin_o === 1'b1 && c < 100) begin
            @(posedge core_clk_in);
            #1 c++;
        end
        while (pin_o !== 1'b1 && c < 100) begin
            @(posedge core_clk_in);
            #1 c++;
        end
    endtask
    initial begin
        do_reset();
        chk(bp, 4'h1);
        chk(sync_oe_b, 1'b1);
        chk(pin_o, 1'b0);
        // ------------------------------------------------------------
        // Device index and bus match
        // ------------------------------------------------------------
        for (int i = 0; i < 20; i++) begin
            {sa, sub} = (i == 0) ? 4'hf : 4'($random(seed));
            bus_dev = (i % 2) ? {sa, sub} : 4'($random(seed));
            repeat (2) @(posedge core_clk_in);
            #1 chk(idx, {sa, sub[2], sub[1], sub[0]});
            chk(sel, bus_dev == {sa, sub});
        end
        $display("Index test done");
        // ------------------------------------------------------------
        // Slave timing per mode, aligned then after a noise step
        // ------------------------------------------------------------
        for (int m = 0; m < 4; m++) begin
            mode = mux_mode_t'(m);
            do_reset();
            chk(pin_oe_b, 1'b1);
            repeat (72) tick();
            skewed = 1;
            skew = 1'b1;
            @(posedge core_clk_in);
            #1 skew = 1'b0;
            repeat (48) tick();
            chk(t_last, 72 - 1 + 24 + first_pull(mode));
            $display("Mode %0d test done", m);
        end
        // ------------------------------------------------------------
        // Master clock rate
        // ------------------------------------------------------------
        master = 1'b1;
        #1 chk(pin_oe_b, 1'b0);
        for (int r = 0; r < 2; r++) begin
            rate = r[0];
            rise_gap(n);
            rise_gap(n);
            chk(n, r ? 8 : 6);
        end
        $display("Master test done");
        summarize();
    end
endmodule // lcd_cascade_frame_sync_tb
